// File: verilog/qulrs_top.sv
/*
  four-channel serial line block: per-channel 8N1 transmitter and
  receiver, two-entry transmit and receive holding buffers, local
  loop-back, combined active-low receive-ready and transmit-ready.
  assumes host strobes are synchronous to clk_i; serial inputs are not.
*/
`timescale 1ns/1ps

// Behaviour
// R01: transmit line high in reset, idle, disabled
// R02: far end keeps receive line high idle
// R03: loop-back mutes pin, feeds transmit into receiver
// R04: loop-back ignores external receive pin
// R05: any-channel receive-ready low when data held
// R06: receive-ready high when nothing left anywhere
// R07: transmit-ready low when any slot free
// R08: transmit-ready high only when all full
// R09: per-channel readiness readable by chip select
// R10: timing from clock input, crystal or external
module qulrs_top
  import qulrs_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // host access, synchronous to clk_i
  input  wire logic              cs_n_i,
  input  wire logic [CH_W-1:0]   chan_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic      [1:0]        stat_o,
  // per-channel controls
  input  wire logic [NUM_CH-1:0] tx_en_i,
  input  wire logic [NUM_CH-1:0] loopback_i,
  // serial lines
  input  wire logic [NUM_CH-1:0] serial_in_i,
  output logic      [NUM_CH-1:0] serial_out_o,
  // readiness, active low
  output logic      [NUM_CH-1:0] rx_avail_n_o,
  output logic      [NUM_CH-1:0] tx_space_n_o,
  output logic                   rx_avail_any_n_o,
  output logic                   tx_space_any_n_o
);

  // ********************************************************************
  // decoding helper
  // ********************************************************************
  // true when chip select is low and chan_i selects channel ch
  function automatic logic chan_hit(input logic cs_n,
                                    input logic [CH_W-1:0] sel,
                                    input int unsigned ch);
    chan_hit = !cs_n && (sel == CH_W'(ch));
  endfunction : chan_hit

  // ********************************************************************
  // shared nets
  // ********************************************************************
  logic [7:0]        tick_cnt;              // oversample divider
  logic              tick;                  // one-cycle oversample pulse
  logic [NUM_CH-1:0] sin_s1;                // sync stage one
  logic [NUM_CH-1:0] sin_s2;                // sync stage two
  logic [NUM_CH-1:0] tx_line;               // transmitter bit level
  logic [NUM_CH-1:0] rx_line;               // receiver input level
  logic [NUM_CH-1:0] rx_vld;                // receive buffer not empty
  logic [NUM_CH-1:0] tx_rdy;                // transmit buffer not full
  logic [NUM_CH-1:0] force_mark;            // pin held at mark
  logic [DATA_W-1:0] rx_dat [NUM_CH];       // receive buffer heads
  wire               host_rd;               // read strobe qualified
  wire               host_wr;               // write strobe qualified

  assign host_rd    = !cs_n_i & rd_i;
  assign host_wr    = !cs_n_i & wr_i;
  assign force_mark = ~tx_en_i | loopback_i;

  // ********************************************************************
  // oversample tick divider
  // ********************************************************************
  // clk_i is the sole reference, from crystal or external source [R10]
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else
    begin
      tick     <= (tick_cnt == TICK_LAST);       // [R10]
      tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 8'h01;
    end
  end

  // ********************************************************************
  // receive pin synchroniser
  // ********************************************************************
  // idle mark on pins resets to high so no false start [R02]
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      sin_s1 <= {NUM_CH{LINE_IDLE}};
      sin_s2 <= {NUM_CH{LINE_IDLE}};
    end
    else
    begin
      sin_s1 <= serial_in_i;
      sin_s2 <= sin_s1;
    end
  end

  // loop-back feeds transmit bits, external pin ignored [R03] [R04]
  assign rx_line = (loopback_i & tx_line) | (~loopback_i & sin_s2);

  // ********************************************************************
  // per-channel transmit and receive
  // ********************************************************************
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    qulrs_strm_if txi ();            // host into transmit buffer
    qulrs_strm_if txo ();            // transmit buffer to shifter
    qulrs_strm_if rxi ();            // receiver into receive buffer
    qulrs_strm_if rxo ();            // receive buffer to host

    qulrs_tx_st_e       tx_st;       // transmitter state
    logic [FRAME_W-1:0] tx_sh;       // outgoing frame
    logic [3:0]         tx_ov;       // ticks within bit
    logic [3:0]         tx_bits;     // frame bit index
    qulrs_rx_st_e       rx_st;       // receiver state
    logic [DATA_W-1:0]  rx_sh;       // incoming character
    logic [3:0]         rx_ov;       // ticks within bit
    logic [3:0]         rx_bits;     // data bit index
    logic               rx_push;     // character complete

    // host write lands in the transmit holding buffer
    assign txi.valid = host_wr & chan_hit(cs_n_i, chan_i, g);
    assign txi.data  = wdata_i;
    // shifter takes a word only when idle and enabled
    assign txo.ready = (tx_st == TX_IDLE) & tx_en_i[g];
    // host read pops the receive holding buffer
    assign rxo.ready = host_rd & chan_hit(cs_n_i, chan_i, g);
    assign rxi.valid = rx_push;
    assign rxi.data  = rx_sh;
    assign rx_dat[g] = rxo.data;
    assign rx_vld[g] = rxo.valid;
    assign tx_rdy[g] = txi.ready;
    // mark level when idle or disabled [R01]
    assign tx_line[g] = (tx_st == TX_SHIFT) & tx_en_i[g] ?
                        tx_sh[0] : LINE_IDLE;

    qulrs_buf2 u_txbuf
    (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .wr_s   (txi),
      .rd_s   (txo)
    );

    qulrs_buf2 u_rxbuf
    (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .wr_s   (rxi),
      .rd_s   (rxo)
    );

    // transmit shifter, aborted by disable
    always_ff @(posedge clk_i)
    begin
      if (!rstn_i || !tx_en_i[g])
      begin
        tx_st   <= TX_IDLE;
        tx_sh   <= FRAME_IDLE;      // [R01]
        tx_ov   <= '0;
        tx_bits <= '0;
      end
      else
      begin
        case (tx_st)
          TX_IDLE:
          begin
            // load stop, data, start
            if (txo.valid)
            begin
              tx_sh   <= {LINE_IDLE, txo.data, LINE_START};
              tx_ov   <= '0;
              tx_bits <= '0;
              tx_st   <= TX_SHIFT;
            end
          end
          TX_SHIFT:
          begin
            if (tick && tx_ov == OVS_LAST)
            begin
              tx_ov   <= '0;
              tx_sh   <= {LINE_IDLE, tx_sh[FRAME_W-1:1]};
              tx_bits <= tx_bits + 4'h1;
              if (tx_bits == FRAME_LAST) tx_st <= TX_IDLE;
            end
            else if (tick)
              tx_ov <= tx_ov + 4'h1;
          end
          default: tx_st <= TX_IDLE;
        endcase
      end
    end

    // receiver: start check mid-bit, sample each bit centre
    always_ff @(posedge clk_i)
    begin
      if (!rstn_i)
      begin
        rx_st   <= RX_IDLE;
        rx_sh   <= '0;
        rx_ov   <= '0;
        rx_bits <= '0;
        rx_push <= 1'b0;
      end
      else
      begin
        rx_push <= 1'b0;
        if (tick)
        begin
          case (rx_st)
            RX_IDLE:
            begin
              rx_ov <= '0;
              if (rx_line[g] == LINE_START) rx_st <= RX_START;
            end
            RX_START:
            begin
              // false start falls back to idle
              rx_ov <= rx_ov + 4'h1;
              if (rx_ov == OVS_MID)
              begin
                rx_ov   <= '0;
                rx_bits <= '0;
                rx_st   <= (rx_line[g] == LINE_START) ? RX_DATA : RX_IDLE;
              end
            end
            RX_DATA:
            begin
              rx_ov <= rx_ov + 4'h1;
              if (rx_ov == OVS_LAST)
              begin
                rx_ov   <= '0;
                rx_sh   <= {rx_line[g], rx_sh[DATA_W-1:1]};
                rx_bits <= rx_bits + 4'h1;
                if (rx_bits == DATA_LAST) rx_st <= RX_STOP;
              end
            end
            RX_STOP:
            begin
              // good stop bit stores; full buffer drops the character
              rx_ov <= rx_ov + 4'h1;
              if (rx_ov == OVS_LAST)
              begin
                rx_push <= (rx_line[g] == LINE_IDLE);
                rx_st   <= RX_IDLE;
              end
            end
            default: rx_st <= RX_IDLE;
          endcase
        end
      end
    end
  end : g_ch

  // ********************************************************************
  // registered pins and readiness
  // ********************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      serial_out_o     <= {NUM_CH{LINE_IDLE}};  // [R01]
      rx_avail_n_o     <= '1;
      tx_space_n_o     <= '1;
      rx_avail_any_n_o <= 1'b1;
      tx_space_any_n_o <= 1'b1;
    end
    else
    begin
      serial_out_o     <= force_mark | tx_line;  // [R01] [R03]
      rx_avail_n_o     <= ~rx_vld;
      tx_space_n_o     <= ~tx_rdy;
      rx_avail_any_n_o <= ~(|rx_vld);            // [R05] [R06]
      tx_space_any_n_o <= ~(|tx_rdy);            // [R07] [R08]
    end
  end

  // ********************************************************************
  // host read data and per-channel status
  // ********************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= '0;
      stat_o  <= '0;
    end
    else if (!cs_n_i)
    begin
      if (rd_i) rdata_o <= rx_dat[chan_i];
      stat_o[STAT_RX] <= rx_vld[chan_i];         // [R09]
      stat_o[STAT_TX] <= tx_rdy[chan_i];         // [R09]
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  sequence s_sel_read;
    !cs_n_i && rd_i;
  endsequence

  property p_reset_mark;
    @(posedge clk_i) $rose(rstn_i) |-> serial_out_o == '1;
  endproperty
  a_reset_mark: assert property (p_reset_mark) // [R01]
    else $error("serial out not high after reset");

  property p_forced_mark;
    @(posedge clk_i) disable iff (!rstn_i)
      1'b1 |=> (serial_out_o & $past(force_mark)) == $past(force_mark);
  endproperty
  a_forced_mark: assert property (p_forced_mark) // [R03]
    else $error("disabled or looped pin not at mark");

  property p_loop_ignores_pin;
    @(posedge clk_i) disable iff (!rstn_i)
      loopback_i[1] && $stable(loopback_i[1]) && $stable(tx_line[1])
        |-> $stable(rx_line[1]);
  endproperty
  a_loop_ignores_pin: assert property (p_loop_ignores_pin) // [R04]
    else $error("external pin reached receiver in loop-back");

  property p_rx_any_low;
    @(posedge clk_i) disable iff (!rstn_i)
      (|rx_vld) |=> !rx_avail_any_n_o;
  endproperty
  a_rx_any_low: assert property (p_rx_any_low) // [R05]
    else $error("receive-ready not low with data held");

  property p_rx_any_high;
    @(posedge clk_i) disable iff (!rstn_i)
      !(|rx_vld) ##1 !(|rx_vld) |-> rx_avail_any_n_o;
  endproperty
  a_rx_any_high: assert property (p_rx_any_high) // [R06]
    else $error("receive-ready low with nothing held");

  property p_tx_any_low;
    @(posedge clk_i) disable iff (!rstn_i)
      (tx_space_n_o != '1) |-> !tx_space_any_n_o;
  endproperty
  a_tx_any_low: assert property (p_tx_any_low) // [R07]
    else $error("transmit-ready high while a slot is free");

  property p_tx_any_high;
    @(posedge clk_i) disable iff (!rstn_i)
      !tx_space_any_n_o |-> tx_space_n_o != '1;
  endproperty
  a_tx_any_high: assert property (p_tx_any_high) // [R08]
    else $error("transmit-ready low with all buffers full");

  property p_stat_read;
    @(posedge clk_i) disable iff (!rstn_i)
      s_sel_read |=> stat_o[STAT_RX] == $past(rx_vld[chan_i]);
  endproperty
  a_stat_read: assert property (p_stat_read) // [R09]
    else $error("status does not match selected channel");

  property p_tick_period;
    @(posedge clk_i) disable iff (!rstn_i)
      tick |=> !tick [*6] ##1 tick;
  endproperty
  a_tick_period: assert property (p_tick_period) // [R10]
    else $error("oversample tick period wrong");

endmodule : qulrs_top

// File: verilog/qulrs_pkg.sv
/*
  shared constants for the four-channel serial line block: channel count,
  character framing, oversampling and tick timing, line levels, state codes.
  assumes a single 125 MHz clock feeding every module of the block.
*/
package qulrs_pkg;

  // ********************************************************************
  // channel and character layout
  // ********************************************************************
  localparam int unsigned NUM_CH     = 4;         // serial channels
  localparam int unsigned CH_W       = 2;         // channel select width
  localparam int unsigned DATA_W     = 8;         // character width
  localparam int unsigned FRAME_W    = 10;        // start + data + stop
  localparam logic [3:0]  DATA_LAST  = 4'h7;      // last data bit index
  localparam logic [3:0]  FRAME_LAST = 4'h9;      // last frame bit index
  localparam logic        LINE_IDLE  = 1'b1;      // mark level of a line
  localparam logic        LINE_START = 1'b0;      // start bit level
  localparam logic [FRAME_W-1:0] FRAME_IDLE = 10'h3_FF; // all mark

  // ********************************************************************
  // timing: clock rate, bit rate, oversampling
  // ********************************************************************
  localparam longint unsigned CLK_HZ  = 125_000_000; // clk_i rate
  localparam longint unsigned BAUD_HZ = 1_000_000;   // serial bit rate
  localparam longint unsigned OVS     = 16;          // ticks per bit
  // longest tick period rounds down, never below one cycle
  localparam longint unsigned TICK_CYC_RAW = CLK_HZ / (BAUD_HZ * OVS);
  localparam longint unsigned TICK_CYC =
    (TICK_CYC_RAW < 1) ? 1 : TICK_CYC_RAW;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1); // divider wrap
  localparam logic [3:0] OVS_LAST  = 4'(OVS - 1);      // last tick of bit
  localparam logic [3:0] OVS_MID   = 4'(OVS / 2);      // mid-bit sample

  // ********************************************************************
  // status word layout for the selected channel
  // ********************************************************************
  localparam int unsigned STAT_RX = 0;  // character available
  localparam int unsigned STAT_TX = 1;  // holding space free

  // ********************************************************************
  // state codes
  // ********************************************************************
  typedef enum logic [0:0] {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } qulrs_tx_st_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } qulrs_rx_st_e;

endpackage : qulrs_pkg

// File: verilog/qulrs_strm_if.sv
/*
  character stream carrier: data with valid and ready between the
  channel logic and its two-entry holding buffers.
  assumes both ends run on clk_i; a word moves when valid and ready.
*/
`timescale 1ns/1ps
interface qulrs_strm_if;
  import qulrs_pkg::*;
  logic [DATA_W-1:0] data;   // character
  logic              valid;  // producer offers data
  logic              ready;  // consumer accepts data

  // producer end
  modport src (output data, output valid, input ready);
  // consumer end
  modport snk (input data, input valid, output ready);
endinterface : qulrs_strm_if

// File: verilog/qulrs_buf2.sv
/*
  two-entry holding buffer with valid/ready on both sides.
  assumes one clock, synchronous active-low reset; full drops ready and takes no word.
*/
`timescale 1ns/1ps
module qulrs_buf2
  import qulrs_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // filling side
  qulrs_strm_if.snk wr_s,
  // draining side
  qulrs_strm_if.src rd_s
);

  logic [DATA_W-1:0] head;   // oldest word
  logic [DATA_W-1:0] tail;   // second word
  logic [1:0]        fill;   // words held, 0..2
  wire               push;   // word accepted
  wire               pop;    // word removed

  // honest full and empty
  assign wr_s.ready = (fill != 2'h2);
  assign rd_s.valid = (fill != 2'h0);
  assign rd_s.data  = head;
  assign push       = wr_s.valid & wr_s.ready;
  assign pop        = rd_s.valid & rd_s.ready;

  // ********************************************************************
  // storage and occupancy
  // ********************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      fill <= 2'h0;
      head <= '0;
      tail <= '0;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          // write into first free slot
          if (fill == 2'h0) head <= wr_s.data;
          else              tail <= wr_s.data;
          fill <= fill + 2'h1;
        end
        2'b01:
        begin
          // shift second word forward
          head <= tail;
          fill <= fill - 2'h1;
        end
        2'b11:
        begin
          // pass-through when one held, else shift and refill
          if (fill == 2'h1) head <= wr_s.data;
          else
          begin
            head <= tail;
            tail <= wr_s.data;
          end
        end
        default: fill <= fill;
      endcase
    end
  end

endmodule : qulrs_buf2

// File: verification/qulrs_far_end.sv
/*
  far-end serial equipment: sends 8N1 characters on the receive lines
  and decodes characters seen on the transmit lines.
  assumes the package bit timing and a clk_i shared with the bench.
*/
`timescale 1ns/1ps
module qulrs_far_end
  import qulrs_pkg::*;
(
  // clock
  input  wire logic              clk_i,
  // serial lines
  input  wire logic [NUM_CH-1:0] serial_out_i,
  output logic      [NUM_CH-1:0] serial_in_o
);
  // ********************************************************************
  // line driver and decoder
  // ********************************************************************
  localparam int BIT_CYC = int'(TICK_CYC * OVS); // cycles per bit

  initial serial_in_o = '1; // lines rest at mark

  // one frame, lsb first, ends back at mark
  task automatic send_char(input int ch, input logic [DATA_W-1:0] c);
    logic [FRAME_W-1:0] f;
    f = {LINE_IDLE, c, LINE_START};
    for (int i = 0; i < FRAME_W; i++)
    begin
      @(posedge clk_i);
      #1 serial_in_o[ch] = f[i]; // stop bit leaves line high
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask : send_char

  // wait for a start bit, then sample each bit at its middle
  task automatic get_char(input int ch, input int lim,
                          output logic [DATA_W-1:0] c, output bit ok);
    int n;
    n = 0;
    ok = 0;
    c = '0;
    while (serial_out_i[ch] !== LINE_START && n < lim)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n < lim)
    begin
      repeat (BIT_CYC / 2) @(posedge clk_i);
      #1 ok = (serial_out_i[ch] === LINE_START);
      for (int i = 0; i < DATA_W; i++)
      begin
        repeat (BIT_CYC) @(posedge clk_i);
        #1 c[i] = serial_out_i[ch];
      end
      repeat (BIT_CYC) @(posedge clk_i);
      #1 ok = ok && (serial_out_i[ch] === LINE_IDLE);
    end
  endtask : get_char
endmodule : qulrs_far_end

// File: verification/tb_top.sv
/*
  self-checking bench for the four-channel serial line block.
  assumes the far-end model answers on the serial lines; host strobes
  are driven 1 ns after the rising clock edge.
*/
`timescale 1ns/1ps
module tb_top;
  import qulrs_pkg::*;
  // ********************************************************************
  // signals and instances
  // ********************************************************************
  logic              clk_i = 1'b0;      // 125 MHz
  logic              rstn_i = 1'b0;     // sync reset
  logic              cs_n_i = 1'b1;     // host select
  logic [CH_W-1:0]   chan_i = '0;       // channel
  logic              wr_i = 1'b0;       // write strobe
  logic              rd_i = 1'b0;       // read strobe
  logic [DATA_W-1:0] wdata_i = '0;      // write data
  logic [NUM_CH-1:0] tx_en_i = '0;      // transmit enables
  logic [NUM_CH-1:0] loopback_i = '0;   // loop-back controls
  logic [DATA_W-1:0] rdata_o;           // read data
  logic [1:0]        stat_o;            // channel status
  logic [NUM_CH-1:0] serial_in_i;       // receive pins
  logic [NUM_CH-1:0] serial_out_o;      // transmit pins
  logic [NUM_CH-1:0] rx_avail_n_o;      // per-channel rx ready
  logic [NUM_CH-1:0] tx_space_n_o;      // per-channel tx ready
  logic              rx_avail_any_n_o;  // combined rx ready
  logic              tx_space_any_n_o;  // combined tx ready
  int                fails = 0;         // mismatches
  int                compares = 0;      // comparisons

  always #4 clk_i = ~clk_i;

  qulrs_top u_qulrs_top (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
    .chan_i(chan_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .stat_o(stat_o), .tx_en_i(tx_en_i),
    .loopback_i(loopback_i), .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o), .rx_avail_n_o(rx_avail_n_o),
    .tx_space_n_o(tx_space_n_o), .rx_avail_any_n_o(rx_avail_any_n_o),
    .tx_space_any_n_o(tx_space_any_n_o));

  qulrs_far_end u_qulrs_far_end (.clk_i(clk_i),
    .serial_out_i(serial_out_o), .serial_in_o(serial_in_i));

  // ********************************************************************
  // shared tasks
  // ********************************************************************
  task automatic chk(input bit good, input string msg);
    compares++;
    if (!good)
    begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic host_wr(input int ch, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    #1 {cs_n_i, wr_i, chan_i, wdata_i} = {1'b0, 1'b1, CH_W'(ch), d};
    @(posedge clk_i);
    #1 {cs_n_i, wr_i} = 2'b10;
  endtask : host_wr

  task automatic host_rd(input int ch, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    #1 {cs_n_i, rd_i, chan_i} = {1'b0, 1'b1, CH_W'(ch)};
    @(posedge clk_i);
    #1 {cs_n_i, rd_i} = 2'b10;
    d = rdata_o;
  endtask : host_rd

  task automatic host_st(input int ch, output logic [1:0] s);
    @(posedge clk_i);
    #1 {cs_n_i, chan_i} = {1'b0, CH_W'(ch)};
    tick(1);
    s = stat_o;
    cs_n_i = 1'b1;
  endtask : host_st

  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // ********************************************************************
  // scenarios
  // ********************************************************************
  task automatic t_reset;
    tick(12);
    chk(serial_out_o === 4'hF, "tx pins not high in reset");
    chk({rx_avail_any_n_o, tx_space_any_n_o} === 2'b11, "rdy in reset");
    rstn_i = 1'b1;
    tick(3);
    chk(tx_space_any_n_o === 1'b0, "tx ready not low");
    chk(rx_avail_any_n_o === 1'b1, "rx ready not high");
    chk(serial_out_o === 4'hF, "idle tx pins not high");
    $display("test reset done");
  endtask : t_reset

  task automatic t_send;
    logic [DATA_W-1:0] c;
    bit ok;
    tx_en_i = 4'h1;
    host_wr(0, 8'hA5);
    u_qulrs_far_end.get_char(0, 300, c, ok);
    chk(ok && c === 8'hA5, "ch0 char wrong");
    tick(2);
    chk(serial_out_o[0] === LINE_IDLE, "ch0 not idle");
    $display("test send done");
  endtask : t_send

  task automatic t_fill;
    logic [DATA_W-1:0] c;
    logic [1:0] s;
    bit ok;
    tx_en_i = 4'h0;
    for (int ch = NUM_CH - 1; ch >= 0; ch--)
    begin
      if (ch == 0)
        chk(tx_space_any_n_o === 1'b0, "one slot left unseen");
      host_wr(ch, 8'h3C);
      host_wr(ch, 8'hC3);
    end
    host_wr(0, 8'hFF);
    tick(3);
    chk(tx_space_any_n_o === 1'b1, "all full not high");
    chk(tx_space_n_o === 4'hF, "per-channel full");
    chk(serial_out_o === 4'hF, "disabled tx pin not high");
    host_st(0, s);
    chk(s[STAT_TX] === 1'b0, "ch0 status space");
    tx_en_i = 4'hF;
    tick(4);
    chk(tx_space_any_n_o === 1'b0, "freed slot unseen");
    u_qulrs_far_end.get_char(0, 300, c, ok);
    chk(ok && c === 8'h3C, "first queued char");
    u_qulrs_far_end.get_char(0, 300, c, ok);
    chk(ok && c === 8'hC3, "second queued char");
    u_qulrs_far_end.get_char(0, 1500, c, ok);
    chk(!ok, "dropped char was sent");
    $display("test fill done");
  endtask : t_fill

  task automatic t_recv;
    logic [DATA_W-1:0] c;
    logic [1:0] s;
    int n;
    u_qulrs_far_end.send_char(2, 8'h96);
    n = 0;
    while (rx_avail_any_n_o !== 1'b0 && n < 200)
    begin
      tick(1);
      n++;
    end
    chk(n < 200 && rx_avail_n_o[2] === 1'b0, "rx ready not low");
    host_st(2, s);
    chk(s[STAT_RX] === 1'b1, "ch2 status avail");
    host_rd(2, c);
    chk(c === 8'h96, "ch2 read data");
    tick(3);
    chk(rx_avail_any_n_o === 1'b1, "rx ready not back high");
    $display("test recv done");
  endtask : t_recv

  task automatic t_loop;
    logic [DATA_W-1:0] c;
    int bad;
    bad = 0;
    loopback_i = 4'h2;
    tx_en_i = 4'h2;
    tick(2);
    fork
      u_qulrs_far_end.send_char(1, 8'h00);
      begin
        host_wr(1, 8'h5A);
        repeat (1300)
        begin
          tick(1);
          if (serial_out_o[1] !== LINE_IDLE)
            bad++;
        end
      end
    join
    chk(bad == 0, "loop-back pin not held high");
    chk(rx_avail_n_o[1] === 1'b0, "looped char missing");
    host_rd(1, c);
    chk(c === 8'h5A, "looped char data");
    tick(3);
    chk(rx_avail_n_o[1] === 1'b1, "pin char got in");
    $display("test loop done");
  endtask : t_loop

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial
  begin
    t_reset();
    t_send();
    t_fill();
    t_recv();
    t_loop();
    close_out();
  end
endmodule : tb_top
